// File: shared/flash_status_pkg.sv
package flash_status_pkg;

  // ----------------------------------------------------------------
  // array geometry and protect decode
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 24;
  localparam logic [23:0] ARRAY_BYTES    = 24'h800000; // 8 MB array
  localparam logic [4:0]  FRAC_SHIFT     = 5'h11;      // 128 KB smallest fraction
  localparam logic [4:0]  SMALL_SHIFT    = 5'h0C;      // 4 KB smallest top/bottom region
  localparam logic [2:0]  SMALL_MAX_STEP = 3'h3;       // small regions stop at 32 KB
  localparam logic [2:0]  BP_NONE        = 3'h0;
  localparam logic [2:0]  BP_ALL         = 3'h7;

  // ----------------------------------------------------------------
  // status word field positions
  // ----------------------------------------------------------------
  localparam int BIT_WIP  = 0;
  localparam int BIT_WEL  = 1;
  localparam int BP_LSB   = 2;
  localparam int BP_MSB   = 6;
  localparam int BIT_STATUS_PROTECT_LOW = 7;
  localparam int BIT_STATUS_PROTECT_HIGH = 8;
  localparam int BIT_QE   = 9;
  localparam int BIT_PROGRAM_SUSPENDED = 10;
  localparam int LB_LSB   = 11;
  localparam int LB_MSB   = 13;
  localparam int BIT_CMP  = 14;
  localparam int BIT_ERASE_SUSPENDED = 15;

  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam int          CNT_W        = 16;

  // ----------------------------------------------------------------
  // commands, protect modes, engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP     = 4'h0,
    CMD_WREN    = 4'h1,
    CMD_WRDI    = 4'h2,
    CMD_WRITE_STATUS_CMD    = 4'h3,
    CMD_PP      = 4'h4,
    CMD_SE      = 4'h5,
    CMD_BE      = 4'h6,
    CMD_CE      = 4'h7,
    CMD_SUSPEND = 4'h8,
    CMD_RESUME  = 4'h9,
    CMD_SWRESET = 4'hA
  } cmd_t;

  typedef enum logic [1:0] {
    SRP_SOFT     = 2'h0,
    SRP_HW       = 2'h1,
    SRP_LOCKDOWN = 2'h2,
    SRP_OTP      = 2'h3
  } srp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_BUSY = 2'h1,
    ST_SUSP = 2'h3
  } op_state_t;

  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_PROG   = 2'h1,
    OP_ERASE  = 2'h2,
    OP_STATUS = 2'h3
  } op_kind_t;

endpackage

// File: core/flash_status_protect.sv
`timescale 1ns/100ps
module flash_status_protect
  import flash_status_pkg::*;
#(
  parameter int PROG_CYCLES   = 16,
  parameter int ERASE_CYCLES  = 64,
  parameter int STATUS_CYCLES = 8
)(
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic                           sclk,
  input  wire logic                           cmdValid,
  input  wire flash_status_pkg::cmd_t         cmdCode,
  input  wire logic [flash_status_pkg::ADDR_W-1:0] cmdAddr,
  input  wire logic [15:0]                    cmdData,
  output logic                                cmdReady,
  input  wire logic                           wpPin_n,
  input  wire logic                           holdPin_n,
  output logic [15:0]                         statusWord,
  output logic                                writeInProgress,
  output logic                                cmdAccepted,
  output logic                                cmdRefused,
  output logic                                quadIoEnable,
  output logic                                holdActive
);
  import flash_status_pkg::*;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]        rstSync;
    logic              reqTgl;
    logic [1:0]        ackSync;
    logic              ready;
    cmd_t              heldCode;
    logic [ADDR_W-1:0] heldAddr;
    logic [15:0]       heldData;
  } link_state_t;

  typedef struct packed {
    logic [1:0]       reqSync;
    logic             reqSeen;
    logic             ackTgl;
    logic [1:0]       wpSync;
    logic [1:0]       holdSync;
    logic [4:0]       blockProtect;
    logic             complementProtect;
    logic [2:0]       securityLock;
    logic             quadEnable;
    srp_mode_t        statusProtect;
    logic             writeEnableLatch;
    logic             eraseSuspended;
    logic             programSuspended;
    op_state_t        opState;
    op_kind_t         opKind;
    logic [CNT_W-1:0] busyCnt;
    logic [15:0]      statusOut;
    logic             accepted;
    logic             refused;
    logic             busyOut;
    logic             quadOut;
    logic             holdOut;
  } core_state_t;

  link_state_t linkQ;
  link_state_t linkD;
  core_state_t coreQ;
  core_state_t coreD;

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  // range for the complement-clear table, then flipped by complement
  function automatic logic protectedHit(input logic [ADDR_W-1:0] addr,
                                        input logic [4:0]        bp,
                                        input logic              cmp);
    logic [2:0]  step;
    logic [4:0]  sh;
    logic [23:0] size;
    logic        hit;
    step = bp[2:0] - 3'h1;
    if (bp[4])
      sh = SMALL_SHIFT + {2'h0, (step > SMALL_MAX_STEP) ? SMALL_MAX_STEP : step};
    else
      sh = FRAC_SHIFT + {2'h0, step};
    size = 24'h000001 << sh;
    if (bp[2:0] == BP_NONE)
      hit = 1'b0;
    else if (bp[2:0] == BP_ALL)
      hit = 1'b1;
    else if (bp[3])
      hit = addr < size;
    else
      hit = addr >= (ARRAY_BYTES - size);
    return hit ^ cmp;
  endfunction

  // ----------------------------------------------------------------
  // link side: command capture and toggle handshake
  // ----------------------------------------------------------------
  // the held fields stay still until the core toggles back, so the
  // core may read them directly once it has seen the request edge
  always_comb
  begin
    linkD         = linkQ;
    linkD.rstSync = {linkQ.rstSync[0], sys_rst};
    linkD.ackSync = {linkQ.ackSync[0], coreQ.ackTgl};
    if (linkQ.ready && cmdValid)
    begin
      linkD.heldCode = cmdCode;
      linkD.heldAddr = cmdAddr;
      linkD.heldData = cmdData;
      linkD.reqTgl   = ~linkQ.reqTgl;
      linkD.ready    = 1'b0;
    end
    else if (!linkQ.ready && (linkQ.ackSync[1] == linkQ.reqTgl))
    begin
      linkD.ready = 1'b1;
    end
    if (linkQ.rstSync[1])
    begin
      linkD.reqTgl   = 1'b0;
      linkD.ready    = 1'b0;
      linkD.heldCode = CMD_NOP;
      linkD.heldAddr = '0;
      linkD.heldData = '0;
    end
  end

  // link register; reset arrives through the two-stage synchroniser
  always_ff @(posedge sclk)
    linkQ <= linkD;

  // ----------------------------------------------------------------
  // core side: status register and write protection
  // ----------------------------------------------------------------
  always_comb
  begin
    logic        newReq, idleNow, susp, wpHigh, srpOpen;
    logic [15:0] wr;
    srpOpen = 1'b0;
    wr      = linkQ.heldData;
    coreD          = coreQ;
    coreD.accepted = 1'b0;
    coreD.refused  = 1'b0;
    coreD.reqSync  = {coreQ.reqSync[0], linkQ.reqTgl};
    coreD.wpSync   = {coreQ.wpSync[0], wpPin_n};
    coreD.holdSync = {coreQ.holdSync[0], holdPin_n};
    newReq  = coreQ.reqSync[1] != coreQ.reqSeen;
    susp    = coreQ.eraseSuspended | coreQ.programSuspended;
    idleNow = (coreQ.opState == ST_IDLE) && !susp;
    // with quad on the pin is a data line and no longer protects
    wpHigh  = coreQ.wpSync[1] | coreQ.quadEnable;
    case (coreQ.statusProtect)
      SRP_SOFT:     srpOpen = 1'b1;
      SRP_HW:       srpOpen = wpHigh;
      SRP_LOCKDOWN: srpOpen = 1'b0;
      SRP_OTP:      srpOpen = 1'b0;
      default:      srpOpen = 1'b0;
    endcase

    // internal operation timer
    if (coreQ.opState == ST_BUSY)
    begin
      if (coreQ.busyCnt == '0)
      begin
        coreD.opState = ST_IDLE;
        coreD.opKind  = OP_NONE;
      end
      else
        coreD.busyCnt = coreQ.busyCnt - 1'b1;
    end

    if (newReq)
    begin
      coreD.reqSeen = coreQ.reqSync[1];
      coreD.ackTgl  = coreQ.reqSync[1];
      coreD.refused = 1'b1;
      case (linkQ.heldCode)
        CMD_WREN:
        begin
          if (coreQ.opState != ST_BUSY)
          begin
            coreD.writeEnableLatch = 1'b1;
            coreD.refused          = 1'b0;
          end
        end
        CMD_WRDI:
        begin
          coreD.writeEnableLatch = 1'b0;
          coreD.refused          = 1'b0;
        end
        CMD_WRITE_STATUS_CMD:
        begin
          if (idleNow && coreQ.writeEnableLatch)
          begin
            coreD.writeEnableLatch = 1'b0;
            if (srpOpen)
            begin
              coreD.blockProtect      = wr[BP_MSB:BP_LSB];
              coreD.statusProtect     = srp_mode_t'({wr[BIT_STATUS_PROTECT_HIGH], wr[BIT_STATUS_PROTECT_LOW]});
              coreD.quadEnable        = wr[BIT_QE];
              coreD.complementProtect = wr[BIT_CMP];
              coreD.securityLock      = coreQ.securityLock | wr[LB_MSB:LB_LSB];
              coreD.opState           = ST_BUSY;
              coreD.opKind            = OP_STATUS;
              coreD.busyCnt           = CNT_W'(STATUS_CYCLES - 1);
              coreD.refused           = 1'b0;
            end
          end
        end
        CMD_PP, CMD_SE, CMD_BE:
        begin
          if (idleNow && coreQ.writeEnableLatch)
          begin
            coreD.writeEnableLatch = 1'b0;
            if (!protectedHit(linkQ.heldAddr, coreQ.blockProtect,
                              coreQ.complementProtect))
            begin
              coreD.opState = ST_BUSY;
              coreD.opKind  = (linkQ.heldCode == CMD_PP) ? OP_PROG : OP_ERASE;
              coreD.busyCnt = (linkQ.heldCode == CMD_PP) ? CNT_W'(PROG_CYCLES - 1)
                                                         : CNT_W'(ERASE_CYCLES - 1);
              coreD.refused = 1'b0;
            end
          end
        end
        CMD_CE:
        begin
          if (idleNow && coreQ.writeEnableLatch)
          begin
            coreD.writeEnableLatch = 1'b0;
            if (((coreQ.blockProtect[2:0] == BP_NONE) && !coreQ.complementProtect) ||
                ((coreQ.blockProtect[2:0] == BP_ALL) && coreQ.complementProtect))
            begin
              coreD.opState = ST_BUSY;
              coreD.opKind  = OP_ERASE;
              coreD.busyCnt = CNT_W'(ERASE_CYCLES - 1);
              coreD.refused = 1'b0;
            end
          end
        end
        CMD_SUSPEND:
        begin
          // status writes cannot be suspended
          if ((coreQ.opState == ST_BUSY) && (coreQ.opKind != OP_STATUS))
          begin
            coreD.opState          = ST_SUSP;
            coreD.eraseSuspended   = coreQ.opKind == OP_ERASE;
            coreD.programSuspended = coreQ.opKind == OP_PROG;
            coreD.refused          = 1'b0;
          end
        end
        CMD_RESUME:
        begin
          if (coreQ.opState == ST_SUSP)
          begin
            coreD.opState          = ST_BUSY;
            coreD.eraseSuspended   = 1'b0;
            coreD.programSuspended = 1'b0;
            coreD.refused          = 1'b0;
          end
        end
        CMD_SWRESET:
        begin
          // abandons any running operation
          coreD.writeEnableLatch = 1'b0;
          coreD.eraseSuspended   = 1'b0;
          coreD.programSuspended = 1'b0;
          coreD.opState          = ST_IDLE;
          coreD.opKind           = OP_NONE;
          coreD.busyCnt          = '0;
          coreD.refused          = 1'b0;
        end
        default: coreD.refused = 1'b1;
      endcase
      coreD.accepted = !coreD.refused;
    end

    // output image, built from next state so it tracks without lag
    coreD.statusOut = {coreD.eraseSuspended, coreD.complementProtect,
                       coreD.securityLock, coreD.programSuspended,
                       coreD.quadEnable, coreD.statusProtect[1],
                       coreD.statusProtect[0], coreD.blockProtect,
                       coreD.writeEnableLatch,
                       coreD.opState == ST_BUSY};
    coreD.busyOut = coreD.opState == ST_BUSY;
    coreD.quadOut = coreD.quadEnable;
    // next quad value, so hold never shows active in a quad cycle
    coreD.holdOut = !coreQ.holdSync[1] && !coreD.quadEnable;

    // power-up: all volatile and stored bits take their defaults
    if (sys_rst)
    begin
      coreD                = '0;
      coreD.statusProtect  = SRP_SOFT;
      coreD.statusOut      = STATUS_RESET;
    end
  end

  // core register
  always_ff @(posedge clk)
    coreQ <= coreD;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmdReady        = linkQ.ready;
  assign statusWord      = coreQ.statusOut;
  assign writeInProgress = coreQ.busyOut;
  assign cmdAccepted     = coreQ.accepted;
  assign cmdRefused      = coreQ.refused;
  assign quadIoEnable    = coreQ.quadOut;
  assign holdActive      = coreQ.holdOut;

endmodule

// File: sim/flash_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// host side of the command link
// ----------------------------------------
module flash_host_model
  import flash_status_pkg::*;
(
  input  wire logic                sclk,
  input  wire logic                cmdReady,
  output logic                     cmdValid,
  output flash_status_pkg::cmd_t   cmdCode,
  output logic [23:0]              cmdAddr,
  output logic [15:0]              cmdData
);
  // idle bus at time zero
  initial
  begin
    cmdValid = 1'b0;
    cmdCode  = CMD_NOP;
    cmdAddr  = 24'h000000;
    cmdData  = 16'h0000;
  end

  // request held until the taking edge; released lines scrambled so stale data cannot pass
  task send(input cmd_t c, input logic [23:0] a, input logic [15:0] d);
    @(negedge sclk);
    cmdValid = 1'b1;
    cmdCode  = c;
    cmdAddr  = a;
    cmdData  = d;
    do @(posedge sclk); while (cmdReady !== 1'b1);
    @(negedge sclk);
    cmdValid = 1'b0;
    cmdCode  = cmd_t'(~c);
    cmdAddr  = ~a;
    cmdData  = ~d;
  endtask
endmodule

// File: sim/flash_status_protect_checker.sv
`timescale 1ns/100ps
module flash_status_protect_checker
  import flash_status_pkg::*;
#(
  parameter int PROG_CYCLES   = 16,
  parameter int ERASE_CYCLES  = 64,
  parameter int STATUS_CYCLES = 8
)(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [15:0] statusWord,
  input wire logic        cmdAccepted,
  input wire logic        cmdRefused,
  input wire logic        quadIoEnable,
  input wire logic        holdActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // length of the current busy stretch
  logic [15:0] wipCnt;
  always_ff @(posedge clk)
    if (sys_rst || !statusWord[0]) wipCnt <= 16'h0000;
    else wipCnt <= wipCnt + 16'h0001;

  // set while a suspend is seen, so a resumed stretch is not timed as a whole one
  logic susSeen;
  always_ff @(posedge clk)
    if (sys_rst) susSeen <= 1'b0;
    else if (statusWord[15] || statusWord[10]) susSeen <= 1'b1;
    else if (!statusWord[0]) susSeen <= 1'b0;

  a_wip_bound: assert property (wipCnt <= ERASE_CYCLES + 2)
    else $error("busy held too long");
  a_wip_length: assert property ($fell(statusWord[0]) && !cmdAccepted && !susSeen
    |-> wipCnt == STATUS_CYCLES || wipCnt == PROG_CYCLES || wipCnt == ERASE_CYCLES)
    else $error("busy stretch has the wrong length");
  a_wel_gate: assert property ($rose(statusWord[0]) && !$past(statusWord[15])
    && !$past(statusWord[10]) |-> $past(statusWord[1]) && !statusWord[1])
    else $error("operation started without latch");
  a_wel_cause: assert property (!$stable(statusWord[1]) |-> cmdAccepted || cmdRefused)
    else $error("latch moved without a command");
  a_nv_write: assert property (!$stable({statusWord[14:11], statusWord[9:2]})
    |-> cmdAccepted && statusWord[0] && $past(statusWord[1]))
    else $error("stored bits changed outside a status write");
  a_sus_ro: assert property ($rose(statusWord[15]) || $rose(statusWord[10])
    |-> cmdAccepted && $fell(statusWord[0]))
    else $error("suspend flag rose without suspend");
  a_lock_otp: assert property (($past(statusWord[13:11]) & ~statusWord[13:11]) == 3'h0)
    else $error("lock bit cleared");
  a_quad_mirror: assert property (quadIoEnable == statusWord[9])
    else $error("quad output differs from status");
  a_hold_func: assert property ($rose(holdActive) |-> !quadIoEnable)
    else $error("hold active in quad mode");
  a_one_shot: assert property (cmdAccepted || cmdRefused |=> !(cmdAccepted || cmdRefused))
    else $error("answer pulse too long");

  c_refused: cover property (cmdRefused);
  c_suspend: cover property ($rose(statusWord[15]));
  c_hold:    cover property ($rose(holdActive));
  c_prog_susp: cover property ($rose(statusWord[10]));
endmodule

bind flash_status_protect flash_status_protect_checker #(
  .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES), .STATUS_CYCLES(STATUS_CYCLES)
) chk_i (.clk(clk), .sys_rst(sys_rst), .statusWord(statusWord), .cmdAccepted(cmdAccepted),
  .cmdRefused(cmdRefused), .quadIoEnable(quadIoEnable), .holdActive(holdActive));

// File: sim/flash_status_protect_tb.sv
`timescale 1ns/100ps
module flash_status_protect_tb;
  import flash_status_pkg::*;
  logic        clk = 1'b0, sclk = 1'b0, sys_rst = 1'b1, wpPin_n = 1'b1, holdPin_n = 1'b1;
  logic        cmdValid, cmdReady, writeInProgress, cmdAccepted, cmdRefused;
  logic        quadIoEnable, holdActive;
  cmd_t        cmdCode;
  logic [23:0] cmdAddr;
  logic [15:0] cmdData, statusWord;
  int          errTotal = 0, nChecks = 0, cyc = 0;

  // ----------------------------------------
  // clocks, unrelated phases
  // ----------------------------------------
  initial forever #20 clk = ~clk;
  initial
  begin
    #7;
    forever #32 sclk = ~sclk;
  end

  flash_status_protect #(.PROG_CYCLES(20), .ERASE_CYCLES(60), .STATUS_CYCLES(6)) uut (
    .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .wpPin_n(wpPin_n),
    .holdPin_n(holdPin_n), .statusWord(statusWord), .writeInProgress(writeInProgress),
    .cmdAccepted(cmdAccepted), .cmdRefused(cmdRefused), .quadIoEnable(quadIoEnable),
    .holdActive(holdActive));

  flash_host_model host (.sclk(sclk), .cmdReady(cmdReady), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task tally_and_finish;
    if (errTotal == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    nChecks++;
    if (g !== e)
    begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one command: answer kind, then status once idle (w=0 looks at the answer cycle)
  task t(input cmd_t c, input logic [23:0] a, input logic [15:0] d, input logic acc,
         input logic [15:0] s, input bit w = 1'b1);
    host.send(c, a, d);
    for (int i = 0; i < 300 && !(cmdAccepted || cmdRefused); i++) @(negedge clk);
    chk({14'h0000, cmdRefused, cmdAccepted}, {14'h0000, !acc, acc});
    for (int i = 0; w && i < 300 && writeInProgress !== 1'b0; i++) @(negedge clk);
    chk(statusWord, s);
    chk({14'h0000, quadIoEnable, writeInProgress}, {14'h0000, s[9], s[0]});
  endtask

  task we(input logic [15:0] s);
    t(CMD_WREN, 24'h000000, 16'h0000, 1'b1, s);
  endtask

  // pins are synchronised, so give them a few cycles to land
  task pins(input logic wp, input logic hold);
    @(negedge clk);
    wpPin_n = wp;
    holdPin_n = hold;
    repeat (4) @(negedge clk);
  endtask

  task rst;
    @(negedge clk);
    sys_rst = 1'b1;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errTotal++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    chk(statusWord, 16'h0000);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0004, 1'b0, 16'h0000);
    we(16'h0002);
    t(CMD_WRDI, 24'h0, 16'h0000, 1'b1, 16'h0000);
    we(16'h0002);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h8C07, 1'b1, 16'h0804);
    we(16'h0806);
    t(CMD_PP, 24'h7E0000, 16'h0, 1'b0, 16'h0804);
    we(16'h0806);
    t(CMD_PP, 24'h7DFFFF, 16'h0, 1'b1, 16'h0804);
    we(16'h0806);
    t(CMD_CE, 24'h0, 16'h0, 1'b0, 16'h0804);
    we(16'h0806);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h4004, 1'b1, 16'h4804);
    we(16'h4806);
    t(CMD_PP, 24'h7DFFFF, 16'h0, 1'b0, 16'h4804);
    we(16'h4806);
    t(CMD_PP, 24'h7E0000, 16'h0, 1'b1, 16'h4804);
    we(16'h4806);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h4064, 1'b1, 16'h4864);
    we(16'h4866);
    t(CMD_SE, 24'h001000, 16'h0, 1'b0, 16'h4864);
    we(16'h4866);
    t(CMD_BE, 24'h000000, 16'h0, 1'b1, 16'h4864);
    we(16'h4866);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h401C, 1'b1, 16'h481C);
    we(16'h481E);
    t(CMD_CE, 24'h0, 16'h0, 1'b1, 16'h481C);
    // erase interrupted by suspend, with commands refused meanwhile
    we(16'h481E);
    t(CMD_SE, 24'h0, 16'h0, 1'b1, 16'h481D, 1'b0);
    t(CMD_WREN, 24'h0, 16'h0, 1'b0, 16'h481D, 1'b0);
    t(CMD_SUSPEND, 24'h0, 16'h0, 1'b1, 16'hC81C, 1'b0);
    we(16'hC81E);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0000, 1'b0, 16'hC81E);
    t(CMD_RESUME, 24'h0, 16'h0, 1'b1, 16'h481E);
    t(CMD_SWRESET, 24'h0, 16'h0, 1'b1, 16'h481C);
    // program interrupted by suspend sets the other flag
    we(16'h481E);
    t(CMD_PP, 24'h0, 16'h0, 1'b1, 16'h481D, 1'b0);
    t(CMD_SUSPEND, 24'h0, 16'h0, 1'b1, 16'h4C1C, 1'b0);
    t(CMD_RESUME, 24'h0, 16'h0, 1'b1, 16'h481C);
    // status protect modes against the write-protect pin
    we(16'h481E);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0080, 1'b1, 16'h0880);
    pins(1'b0, 1'b1);
    we(16'h0882);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0084, 1'b0, 16'h0880);
    pins(1'b1, 1'b1);
    we(16'h0882);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0104, 1'b1, 16'h0904);
    we(16'h0906);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0000, 1'b0, 16'h0904);
    rst();
    chk(statusWord, 16'h0000);
    // quad mode: bench drives both pins, none tied to a rail
    we(16'h0002);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0200, 1'b1, 16'h0200);
    pins(1'b0, 1'b0);
    chk({15'h0000, holdActive}, 16'h0000);
    we(16'h0202);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0280, 1'b1, 16'h0280);
    we(16'h0282);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0180, 1'b1, 16'h0180);
    repeat (4) @(negedge clk);
    chk({15'h0000, holdActive}, 16'h0001);
    we(16'h0182);
    t(CMD_WRITE_STATUS_CMD, 24'h0, 16'h0000, 1'b0, 16'h0180);
    tally_and_finish();
  end
endmodule
